// File: logic/ivp_pkg.sv
// Constants and types of the interrupt vectoring and priority block
// Notes on behaviour
// - Vector table is the first 256 bytes of the interrupt segment.
// - After reset the start address is fetched from bytes 000000h and 000001h.
// - Top-level routine address is fetched from 0004h/0005h of the interrupt segment.
// - Vector upper bits come from the peripheral base, low bits from hardware.
// - Divide-by-zero vectors through 0002h/0003h of the current code segment.
// - Divide-by-zero does not push flags; its handler ends with a plain return.
// - Segment save off: push PC and flags only, fetch from interrupt segment.
// - Segment save off: code segment writes do not steer fetch inside a routine.
// - Segment save on: push code segment too, then load it from interrupt segment.
// - Segment save on: interrupt return also pops the code segment.
// - Each channel has a three-bit priority, 0 highest and 7 lowest.
// - Top level is reserved; its routine can never be interrupted; the code still lets a divide trap enter it.
// - Top-level channel is either maskable or non-maskable, by selection.
// - Eight external channels, each with selectable trigger edge.
// - A request is taken only when enabled and allowed by priority; top-level skips priority, and skips the enable when non-maskable.
// - One vector base serves two channels, told apart by the low channel bit.
// - Maskable request acknowledged only if its priority is below current level.
// - Current priority level resets to 7.
// - Entry: clear enable, push PC low, PC high, segment if on, flags, load PC.
// - Equal-priority ties go to the channel highest in the fixed chain.
package ivp_pkg;
   localparam int          NUM_EXT      = 8;
   localparam int          NUM_PER      = 8;
   localparam int          NUM_CH       = NUM_EXT + NUM_PER;
   localparam int          NUM_GRP      = NUM_CH / 2;
   localparam logic [2:0]  PRL_LOWEST   = 3'h7;
   localparam logic [2:0]  CPL_RST      = 3'h7;
   localparam logic [7:0]  CS_RST       = 8'h00;
   localparam logic [23:0] RST_VEC_ADDR = 24'h000000;
   localparam logic [15:0] DZ_VEC_OFS   = 16'h0002;
   localparam logic [15:0] TL_VEC_OFS   = 16'h0004;
   localparam logic [7:0]  VEC_TBL_PAGE = 8'h00;
   localparam logic [23:0] ADDR_ODD     = 24'h000001;

   typedef logic [NUM_CH-1:0][2:0]  ivp_prl_arr_t;
   typedef logic [NUM_GRP-1:0][7:0] ivp_vec_arr_t;
   typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP, OP_FETCH} ivp_op_t;
   typedef enum logic [1:0] {K_INT, K_TL, K_DZ} ivp_kind_t;
   typedef enum logic [3:0] {
      S_RST_HI, S_RST_LO, S_IDLE, S_PUSH_PCL, S_PUSH_PCH, S_PUSH_CS, S_PUSH_FLG,
      S_VEC_HI, S_VEC_LO, S_POP_FLG, S_POP_CS, S_POP_PCH, S_POP_PCL
   } ivp_state_t;
endpackage

// File: logic/ivp_arb_if.sv
// Carrier between the core and its priority arbiter
`timescale 1ns/1ps
interface ivp_arb_if;
   import ivp_pkg::*;
   logic [NUM_CH-1:0] req;
   ivp_prl_arr_t      channel_priority_level;
   logic [2:0]        current_priority_level;
   logic              win_valid;
   logic [3:0]        win_idx;
   modport arb  (input req, input channel_priority_level, input current_priority_level, output win_valid, output win_idx);
   modport core (output req, output channel_priority_level, output current_priority_level, input win_valid, input win_idx);
endinterface

// File: logic/ivp_arbiter.sv
// Priority arbiter with fixed chain tie-break
`timescale 1ns/1ps
module ivp_arbiter (
   ivp_arb_if.arb bus
);
   import ivp_pkg::*;
   logic       found;
   logic [3:0] idx;
   logic [2:0] best;

   // Strict compare, lowest index wins ties
   always_comb begin
      found = 1'b0;
      idx   = 4'h0;
      best  = PRL_LOWEST;
      for (int i = 0; i < NUM_CH; i++) begin
         if (bus.req[i] && (bus.channel_priority_level[i] < bus.current_priority_level) && (!found || bus.channel_priority_level[i] < best)) begin
            found = 1'b1;
            idx   = 4'(i);
            best  = bus.channel_priority_level[i];
         end
      end
      bus.win_valid = found;
      bus.win_idx   = idx;
   end
endmodule // ivp_arbiter

// File: logic/ivp_core.sv
// Interrupt entry, vectoring and return sequencer
`timescale 1ns/1ps
module ivp_core (
   input  wire logic                          i_mclk,
   input  wire logic                          i_srst,
   input  wire logic [ivp_pkg::NUM_EXT-1:0]   i_ext_pin,
   input  wire logic [ivp_pkg::NUM_EXT-1:0]   i_ext_rise_sel,
   input  wire logic [ivp_pkg::NUM_PER-1:0]   i_per_req,
   input  wire ivp_pkg::ivp_prl_arr_t         i_prl,
   input  wire ivp_pkg::ivp_vec_arr_t         i_vec_base,
   input  wire logic [7:0]                    i_int_seg,
   input  wire logic                          i_seg_save_en,
   input  wire logic                          i_tl_pin,
   input  wire logic                          i_tl_nonmask,
   input  wire logic                          i_tl_mask_en,
   input  wire logic                          i_ie_set,
   input  wire logic                          i_ie_clr,
   input  wire logic                          i_cpl_wr,
   input  wire logic [2:0]                    i_cpl_wdata,
   input  wire logic                          i_cs_wr,
   input  wire logic [7:0]                    i_cs_wdata,
   input  wire logic                          i_instr_boundary,
   input  wire logic                          i_div_zero,
   input  wire logic                          i_iret,
   input  wire logic [15:0]                   i_pc,
   input  wire logic [7:0]                    i_flags,
   input  wire logic                          i_op_done,
   input  wire logic [7:0]                    i_op_rdata,
   output logic                               o_op_valid,
   output ivp_pkg::ivp_op_t                   o_op_kind,
   output logic [23:0]                        o_op_addr,
   output logic [7:0]                         o_op_data,
   output logic                               o_pc_load,
   output logic [15:0]                        o_pc_value,
   output logic                               o_flag_load,
   output logic [7:0]                         o_flag_value,
   output logic                               o_ack,
   output logic [3:0]                         o_ack_chan,
   output logic                               o_tl_ack,
   output logic                               o_busy,
   output logic                               o_global_ie,
   output logic [2:0]                         o_cpl,
   output logic [7:0]                         o_code_seg,
   output logic [7:0]                         o_fetch_seg,
   output logic                               o_tl_active
);
   import ivp_pkg::*;

   ivp_arb_if arb_bus ();
   ivp_arbiter u_arb (.bus(arb_bus));

   // Pin synchronisers; third stage only for edge detection
   logic [NUM_EXT-1:0] ext_s1_r, ext_s2_r, ext_s3_r, ext_edge;
   logic               tl_s1_r, tl_s2_r, tl_s3_r, tl_edge;

   ivp_state_t  state_r, state_nxt;
   ivp_kind_t   kind_r, kind_nxt;
   ivp_op_t     op_kind_r, op_kind_nxt;
   logic        op_valid_r, op_valid_nxt;
   logic [23:0] op_addr_r, op_addr_nxt;
   logic [7:0]  op_data_r, op_data_nxt;
   logic [23:0] vec_addr_r, vec_addr_nxt;
   logic [15:0] ctx_pc_r, ctx_pc_nxt;
   logic [7:0]  ctx_flg_r, ctx_flg_nxt;
   logic [7:0]  vhi_r, vhi_nxt;
   logic        pc_load_r, pc_load_nxt;
   logic [15:0] pc_val_r, pc_val_nxt;
   logic        flag_load_r, flag_load_nxt;
   logic [7:0]  flag_val_r, flag_val_nxt;
   logic        ack_r, ack_nxt;
   logic [3:0]  ack_chan_r, ack_chan_nxt;
   logic        tl_ack_r, tl_ack_nxt;
   logic        ie_r, ie_nxt;
   logic [2:0]  cpl_r, cpl_nxt;
   logic [7:0]  cs_r, cs_nxt;
   logic        isr_mode_r, isr_mode_nxt;
   logic        tl_act_r, tl_act_nxt;
   logic        busy_r, busy_nxt;
   logic [7:0]  fetch_seg_r, fetch_seg_nxt;
   logic [NUM_EXT-1:0] ext_pend_r, ext_pend_nxt;
   logic        tl_pend_r, tl_pend_nxt;
   logic        tl_ok;
   logic [7:0]  win_vec;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ext_s1_r <= '0;
         ext_s2_r <= '0;
         ext_s3_r <= '0;
         tl_s1_r  <= 1'b0;
         tl_s2_r  <= 1'b0;
         tl_s3_r  <= 1'b0;
      end else begin
         ext_s1_r <= i_ext_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         tl_s1_r  <= i_tl_pin;
         tl_s2_r  <= tl_s1_r;
         tl_s3_r  <= tl_s2_r;
      end
   end

   assign ext_edge = (i_ext_rise_sel & ext_s2_r & ~ext_s3_r)
                   | (~i_ext_rise_sel & ~ext_s2_r & ext_s3_r);
   assign tl_edge  = tl_s2_r & ~tl_s3_r;

   assign arb_bus.req = {i_per_req, ext_pend_r};
   assign arb_bus.channel_priority_level = i_prl;
   assign arb_bus.current_priority_level = cpl_r;

   // Base high bits, channel picks low bits; entries are word aligned
   assign win_vec = {i_vec_base[arb_bus.win_idx[3:1]][7:2], arb_bus.win_idx[0], 1'b0};
   // Top level either ignores or obeys the enable
   assign tl_ok = tl_pend_r && (i_tl_nonmask || (ie_r && i_tl_mask_en));

   always_comb begin
      state_nxt     = state_r;
      kind_nxt      = kind_r;
      vec_addr_nxt  = vec_addr_r;
      ctx_pc_nxt    = ctx_pc_r;
      ctx_flg_nxt   = ctx_flg_r;
      vhi_nxt       = vhi_r;
      pc_load_nxt   = 1'b0;
      pc_val_nxt    = pc_val_r;
      flag_load_nxt = 1'b0;
      flag_val_nxt  = flag_val_r;
      ack_nxt       = 1'b0;
      ack_chan_nxt  = ack_chan_r;
      tl_ack_nxt    = 1'b0;
      ie_nxt        = ie_r;
      cpl_nxt       = cpl_r;
      cs_nxt        = cs_r;
      isr_mode_nxt  = isr_mode_r;
      tl_act_nxt    = tl_act_r;
      // New edges always land, even on the clearing cycle
      ext_pend_nxt  = ext_pend_r | ext_edge;
      tl_pend_nxt   = tl_pend_r | tl_edge;
      if (i_ie_set) begin
         ie_nxt = 1'b1;
      end else if (i_ie_clr) begin
         ie_nxt = 1'b0;
      end
      if (i_cpl_wr) begin
         cpl_nxt = i_cpl_wdata;
      end
      if (i_cs_wr) begin
         cs_nxt = i_cs_wdata;
      end
      case (state_r)
         S_RST_HI: if (i_op_done) begin
            vhi_nxt   = i_op_rdata;
            state_nxt = S_RST_LO;
         end
         S_RST_LO: if (i_op_done) begin
            pc_load_nxt = 1'b1;
            pc_val_nxt  = {vhi_r, i_op_rdata};
            state_nxt   = S_IDLE;
         end
         S_IDLE: if (i_instr_boundary) begin
            ctx_pc_nxt  = i_pc;
            ctx_flg_nxt = i_flags;
            if (i_div_zero) begin
               // Trap vector in the running code segment
               kind_nxt     = K_DZ;
               vec_addr_nxt = {cs_r, DZ_VEC_OFS};
               state_nxt    = S_PUSH_PCL;
            end else if (i_iret) begin
               state_nxt = S_POP_FLG;
            // Top-level routine blocks further interrupt entries; a divide trap still enters
            end else if (tl_ok && !tl_act_r) begin
               // Top-level vector in the interrupt segment
               kind_nxt     = K_TL;
               tl_pend_nxt  = tl_edge;
               tl_ack_nxt   = 1'b1;
               tl_act_nxt   = 1'b1;
               ie_nxt       = 1'b0;
               vec_addr_nxt = {i_int_seg, TL_VEC_OFS};
               state_nxt    = S_PUSH_PCL;
            // Enable and priority must both allow it
            end else if (ie_r && arb_bus.win_valid && !tl_act_r) begin
               kind_nxt     = K_INT;
               ack_nxt      = 1'b1;
               ack_chan_nxt = arb_bus.win_idx;
               if (arb_bus.win_idx < 4'(NUM_EXT)) begin
                  ext_pend_nxt[arb_bus.win_idx[2:0]] = ext_edge[arb_bus.win_idx[2:0]];
               end
               ie_nxt       = 1'b0;
               // Table occupies the first 256 bytes
               vec_addr_nxt = {i_int_seg, VEC_TBL_PAGE, win_vec};
               state_nxt    = S_PUSH_PCL;
            end
         end
         S_PUSH_PCL: if (i_op_done) begin
            state_nxt = S_PUSH_PCH;
         end
         S_PUSH_PCH: if (i_op_done) begin
            if (kind_r == K_DZ) begin
               state_nxt = S_VEC_HI;
            end else if (i_seg_save_en) begin
               state_nxt = S_PUSH_CS;
            end else begin
               state_nxt = S_PUSH_FLG;
            end
         end
         S_PUSH_CS: if (i_op_done) begin
            state_nxt = S_PUSH_FLG;
         end
         S_PUSH_FLG: if (i_op_done) begin
            state_nxt = S_VEC_HI;
         end
         S_VEC_HI: if (i_op_done) begin
            vhi_nxt   = i_op_rdata;
            state_nxt = S_VEC_LO;
         end
         S_VEC_LO: if (i_op_done) begin
            pc_load_nxt = 1'b1;
            pc_val_nxt  = {vhi_r, i_op_rdata};
            state_nxt   = S_IDLE;
            if (kind_r != K_DZ) begin
               if (i_seg_save_en) begin
                  cs_nxt = i_int_seg;
               end else begin
                  isr_mode_nxt = 1'b1;
               end
            end
         end
         S_POP_FLG: if (i_op_done) begin
            flag_load_nxt = 1'b1;
            flag_val_nxt  = i_op_rdata;
            // Segment restored only while segment saving is on at return
            state_nxt     = i_seg_save_en ? S_POP_CS : S_POP_PCH;
         end
         S_POP_CS: if (i_op_done) begin
            cs_nxt    = i_op_rdata;
            state_nxt = S_POP_PCH;
         end
         S_POP_PCH: if (i_op_done) begin
            vhi_nxt   = i_op_rdata;
            state_nxt = S_POP_PCL;
         end
         S_POP_PCL: if (i_op_done) begin
            pc_load_nxt  = 1'b1;
            pc_val_nxt   = {vhi_r, i_op_rdata};
            ie_nxt       = 1'b1;
            isr_mode_nxt = 1'b0;
            tl_act_nxt   = 1'b0;
            state_nxt    = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase

      // Bus request registered on entry to each state
      op_valid_nxt = 1'b1;
      op_kind_nxt  = OP_PUSH;
      op_addr_nxt  = 24'h000000;
      op_data_nxt  = 8'h00;
      case (state_nxt)
         S_RST_HI: begin
            op_kind_nxt = OP_FETCH;
            op_addr_nxt = RST_VEC_ADDR;
         end
         S_RST_LO: begin
            op_kind_nxt = OP_FETCH;
            op_addr_nxt = RST_VEC_ADDR | ADDR_ODD;
         end
         S_PUSH_PCL: op_data_nxt = ctx_pc_nxt[7:0];
         S_PUSH_PCH: op_data_nxt = ctx_pc_nxt[15:8];
         S_PUSH_CS:  op_data_nxt = cs_nxt;
         S_PUSH_FLG: op_data_nxt = ctx_flg_nxt;
         S_VEC_HI: begin
            op_kind_nxt = OP_FETCH;
            op_addr_nxt = vec_addr_nxt;
         end
         S_VEC_LO: begin
            op_kind_nxt = OP_FETCH;
            op_addr_nxt = vec_addr_nxt | ADDR_ODD;
         end
         S_POP_FLG, S_POP_CS, S_POP_PCH, S_POP_PCL: op_kind_nxt = OP_POP;
         default: begin
            op_valid_nxt = 1'b0;
            op_kind_nxt  = OP_NONE;
         end
      endcase
      // Segment writes stay hidden while in interrupt-segment mode
      fetch_seg_nxt = isr_mode_nxt ? i_int_seg : cs_nxt;
      // Registered so the output comes from a flop
      busy_nxt      = (state_nxt != S_IDLE);
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         // Start address fetch from physical zero
         state_r     <= S_RST_HI;
         op_valid_r  <= 1'b1;
         op_kind_r   <= OP_FETCH;
         op_addr_r   <= RST_VEC_ADDR;
         op_data_r   <= 8'h00;
         kind_r      <= K_INT;
         vec_addr_r  <= 24'h000000;
         ctx_pc_r    <= 16'h0000;
         ctx_flg_r   <= 8'h00;
         vhi_r       <= 8'h00;
         pc_load_r   <= 1'b0;
         pc_val_r    <= 16'h0000;
         flag_load_r <= 1'b0;
         flag_val_r  <= 8'h00;
         ack_r       <= 1'b0;
         ack_chan_r  <= 4'h0;
         tl_ack_r    <= 1'b0;
         ie_r        <= 1'b0;
         cpl_r       <= CPL_RST;
         cs_r        <= CS_RST;
         isr_mode_r  <= 1'b0;
         tl_act_r    <= 1'b0;
         fetch_seg_r <= CS_RST;
         ext_pend_r  <= '0;
         tl_pend_r   <= 1'b0;
         busy_r      <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         op_valid_r  <= op_valid_nxt;
         op_kind_r   <= op_kind_nxt;
         op_addr_r   <= op_addr_nxt;
         op_data_r   <= op_data_nxt;
         kind_r      <= kind_nxt;
         vec_addr_r  <= vec_addr_nxt;
         ctx_pc_r    <= ctx_pc_nxt;
         ctx_flg_r   <= ctx_flg_nxt;
         vhi_r       <= vhi_nxt;
         pc_load_r   <= pc_load_nxt;
         pc_val_r    <= pc_val_nxt;
         flag_load_r <= flag_load_nxt;
         flag_val_r  <= flag_val_nxt;
         ack_r       <= ack_nxt;
         ack_chan_r  <= ack_chan_nxt;
         tl_ack_r    <= tl_ack_nxt;
         ie_r        <= ie_nxt;
         cpl_r       <= cpl_nxt;
         cs_r        <= cs_nxt;
         isr_mode_r  <= isr_mode_nxt;
         tl_act_r    <= tl_act_nxt;
         fetch_seg_r <= fetch_seg_nxt;
         ext_pend_r  <= ext_pend_nxt;
         tl_pend_r   <= tl_pend_nxt;
         busy_r      <= busy_nxt;
      end
   end

   assign o_op_valid   = op_valid_r;
   assign o_op_kind    = op_kind_r;
   assign o_op_addr    = op_addr_r;
   assign o_op_data    = op_data_r;
   assign o_pc_load    = pc_load_r;
   assign o_pc_value   = pc_val_r;
   assign o_flag_load  = flag_load_r;
   assign o_flag_value = flag_val_r;
   assign o_ack        = ack_r;
   assign o_ack_chan   = ack_chan_r;
   assign o_tl_ack     = tl_ack_r;
   assign o_busy       = busy_r;
   assign o_global_ie  = ie_r;
   assign o_cpl        = cpl_r;
   assign o_code_seg   = cs_r;
   assign o_fetch_seg  = fetch_seg_r;
   assign o_tl_active  = tl_act_r;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   a_rst_vec_fetch: assert property (
      @(posedge i_mclk) disable iff (1'b0)
      i_srst |=> (o_op_valid && o_op_kind == OP_FETCH && o_op_addr == RST_VEC_ADDR))
      else $error("reset vector fetch not at address zero");
   a_rst_cpl_seven: assert property (
      @(posedge i_mclk) disable iff (1'b0) i_srst |=> (o_cpl == CPL_RST))
      else $error("priority level not seven after reset");
   a_dz_vec_addr: assert property (
      (state_r == S_VEC_HI && kind_r == K_DZ) |-> (o_op_addr == {cs_r, DZ_VEC_OFS}))
      else $error("divide trap vector address wrong");
   a_dz_no_flags: assert property (
      (state_r == S_PUSH_PCH && kind_r == K_DZ && i_op_done) |=> (state_r == S_VEC_HI))
      else $error("divide trap pushed more than the PC");
   a_tl_vec_addr: assert property (
      (state_r == S_VEC_HI && kind_r == K_TL) |-> (o_op_addr[15:0] == TL_VEC_OFS))
      else $error("top-level vector address wrong");
   a_vec_in_table: assert property (
      (state_r == S_VEC_HI && kind_r == K_INT) |-> (o_op_addr[15:8] == VEC_TBL_PAGE))
      else $error("vector outside the first 256 bytes");
   a_ack_strict_prl: assert property (
      (state_r == S_IDLE && ack_nxt) |-> (i_prl[arb_bus.win_idx] < cpl_r))
      else $error("acknowledged without strict priority");
   a_entry_order: assert property (
      o_ack |-> (!o_global_ie && state_r == S_PUSH_PCL && o_op_data == ctx_pc_r[7:0]))
      else $error("entry did not start with enable clear and PC low push");
   a_seg_push: assert property (
      (state_r == S_PUSH_PCH && i_op_done && kind_r != K_DZ && i_seg_save_en)
      |=> (state_r == S_PUSH_CS && o_op_data == cs_r))
      else $error("code segment not pushed when saving is on");
   a_tl_blocks: assert property (
      tl_act_r |-> (!ack_nxt && !tl_ack_nxt))
      else $error("top-level routine was interrupted");
   a_boundary_only: assert property (
      (state_r == S_IDLE && state_nxt == S_PUSH_PCL) |-> i_instr_boundary)
      else $error("entry started off an instruction boundary");
   a_isr_fetch: assert property (
      (isr_mode_r && !i_srst) |=> (isr_mode_r == 1'b0 || o_fetch_seg == $past(i_int_seg)))
      else $error("fetch segment left interrupt segment in routine");
endmodule // ivp_core

// File: dv/ivp_mem_model.sv
// Memory and stack responder on the far side of the op bus
`timescale 1ns/1ps
module ivp_mem_model (
   input  wire logic             i_mclk,
   input  wire logic             i_srst,
   input  wire logic             i_slow,
   input  wire logic             i_op_valid,
   input  wire ivp_pkg::ivp_op_t i_op_kind,
   input  wire logic [23:0]      i_op_addr,
   input  wire logic [7:0]       i_op_data,
   output logic                  o_op_done,
   output logic [7:0]            o_op_rdata
);
   import ivp_pkg::*;
   logic [7:0] stk [0:15];
   int         sp;
   logic       held;
   always @(posedge i_mclk) begin
      if (i_srst) begin
         o_op_done  <= 1'b0;
         o_op_rdata <= 8'h00;
         held       <= 1'b0;
         sp = 0;
      end else if (o_op_done || !i_op_valid) begin
         // Released data scrambled, never left standing
         o_op_done  <= 1'b0;
         o_op_rdata <= ~o_op_rdata;
         held       <= 1'b0;
      end else if (i_slow && !held) begin
         held <= 1'b1;
      end else begin
         o_op_done <= 1'b1;
         if (i_op_kind == OP_PUSH) begin
            stk[sp[3:0]] = i_op_data;
            sp++;
         end
         // pops return bytes in reverse order
         if (i_op_kind == OP_POP) begin
            sp--;
            o_op_rdata <= stk[sp[3:0]];
         end
         if (i_op_kind == OP_FETCH) o_op_rdata <= i_op_addr[7:0] ^ i_op_addr[23:16] ^ 8'hA5;
      end
   end
endmodule // ivp_mem_model

// File: dv/interrupt_vectoring_priority_tb.sv
// Self-checking bench for the interrupt entry sequencer
`timescale 1ns/1ps
module interrupt_vectoring_priority_tb;
   import ivp_pkg::*;
   logic i_mclk = 1'b0, i_srst = 1'b1, i_seg_save_en = 1'b0, i_tl_pin = 1'b0, slow = 1'b0;
   logic i_tl_nonmask = 1'b1, i_tl_mask_en = 1'b0, i_ie_set = 1'b0, i_ie_clr = 1'b0;
   logic i_cpl_wr = 1'b0, i_cs_wr = 1'b0, i_instr_boundary = 1'b1, i_div_zero = 1'b0;
   logic i_iret = 1'b0, i_op_done, o_op_valid, o_pc_load, o_flag_load, o_ack, o_tl_ack;
   logic o_busy, o_global_ie, o_tl_active;
   logic [7:0] i_ext_pin = 8'h00, i_ext_rise_sel = 8'hFF, i_per_req = 8'h00, i_int_seg = 8'h5A;
   logic [7:0] i_cs_wdata = 8'h33, i_flags = 8'hC3, i_op_rdata, o_op_data, o_flag_value;
   logic [7:0] o_code_seg, o_fetch_seg;
   logic [2:0] i_cpl_wdata = 3'h3, o_cpl;
   logic [15:0] i_pc = 16'hBE10, o_pc_value;
   logic [23:0] o_op_addr;
   logic [3:0] o_ack_chan;
   ivp_op_t o_op_kind;
   ivp_prl_arr_t i_prl;
   ivp_vec_arr_t i_vec_base;
   logic [33:0] opq [$];
   int bad_count = 0, num_checks = 0, ack_cnt = 0, cyc = 0;
   ivp_core u_dut (.i_mclk, .i_srst, .i_ext_pin, .i_ext_rise_sel, .i_per_req, .i_prl,
      .i_vec_base, .i_int_seg, .i_seg_save_en, .i_tl_pin, .i_tl_nonmask, .i_tl_mask_en,
      .i_ie_set, .i_ie_clr, .i_cpl_wr, .i_cpl_wdata, .i_cs_wr, .i_cs_wdata, .i_instr_boundary,
      .i_div_zero, .i_iret, .i_pc, .i_flags, .i_op_done, .i_op_rdata, .o_op_valid, .o_op_kind,
      .o_op_addr, .o_op_data, .o_pc_load, .o_pc_value, .o_flag_load, .o_flag_value, .o_ack,
      .o_ack_chan, .o_tl_ack, .o_busy, .o_global_ie, .o_cpl, .o_code_seg, .o_fetch_seg,
      .o_tl_active);
   ivp_mem_model u_mem (.i_mclk, .i_srst, .i_slow(slow), .i_op_valid(o_op_valid),
      .i_op_kind(o_op_kind), .i_op_addr(o_op_addr), .i_op_data(o_op_data),
      .o_op_done(i_op_done), .o_op_rdata(i_op_rdata));
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cyc++;
      if (o_op_valid && i_op_done) opq.push_back({o_op_kind, o_op_addr, o_op_data});
      if (o_ack || o_tl_ack) ack_cnt++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   function automatic logic [7:0] fx(logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'hA5;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic exp_op(ivp_op_t k, logic [23:0] a, logic [7:0] d);
      logic [33:0] g;
      g = opq.pop_front();
      if (k != OP_PUSH) g[7:0] = d;
      if (k == OP_POP) g[31:8] = a;
      chk("op", {k, a, d}, g);
   endtask
   // Sel 0 ack, 1 top-level ack, 2 pc load; bounded wait
   task automatic wait_ev(int sel);
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         #1 n++;
      end while ((sel == 0 ? o_ack : sel == 1 ? o_tl_ack : o_pc_load) !== 1'b1 && n < 300);
      if (n >= 300) chk("event", 0, 1);
   endtask
   task automatic pulse(int sel);
      @(posedge i_mclk);
      case (sel)
         0: i_ie_set <= 1'b1;
         1: i_iret <= 1'b1;
         2: i_div_zero <= 1'b1;
         3: i_cs_wr <= 1'b1;
         default: i_cpl_wr <= 1'b1;
      endcase
      @(posedge i_mclk);
      {i_ie_set, i_iret, i_div_zero, i_cs_wr, i_cpl_wr} <= '0;
   endtask
   task automatic quiet(int n);
      int c0;
      c0 = ack_cnt;
      repeat (n) @(posedge i_mclk);
      chk("acks", c0, ack_cnt);
   endtask
   task automatic take(int sel, logic [3:0] ch, logic [23:0] va);
      opq.delete();
      wait_ev(sel);
      if (sel == 0) chk("ack_chan", ch, o_ack_chan);
      @(posedge i_mclk);
      if (sel == 0 && ch[3]) i_per_req[ch[2:0]] <= 1'b0;
      wait_ev(2);
      chk("pc_value", {fx(va), fx(va + 24'h1)}, o_pc_value);
      exp_op(OP_PUSH, 24'h0, i_pc[7:0]);
      exp_op(OP_PUSH, 24'h0, i_pc[15:8]);
      if (i_seg_save_en) exp_op(OP_PUSH, 24'h0, 8'h33);
      exp_op(OP_PUSH, 24'h0, i_flags);
      exp_op(OP_FETCH, va, 8'h0);
      exp_op(OP_FETCH, va + 24'h1, 8'h0);
   endtask
   task automatic leave(string name);
      pulse(1);
      wait_ev(2);
      chk("ret_pc", i_pc, o_pc_value);
      chk("ret_flags", i_flags, o_flag_value);
      chk("busy", 1'b0, o_busy);
      chk("ret_seg", 8'h33, o_fetch_seg);
      $display("test %s done", name);
   endtask
   initial begin
      i_prl = {16{3'h7}};
      i_prl[1] = 3'h2;
      i_prl[8] = 3'h3;
      i_prl[9] = 3'h3;
      i_prl[10] = 3'h3;
      i_vec_base = '0;
      i_vec_base[0] = 8'h20;
      i_vec_base[4] = 8'h40;
      i_vec_base[5] = 8'h60;
      repeat (16) @(posedge i_mclk);
      i_srst <= 1'b0;
      wait_ev(2);
      chk("start_pc", {fx(24'h0), fx(24'h1)}, o_pc_value);
      chk("cpl", 3'h7, o_cpl);
      chk("ie", 1'b0, o_global_ie);
      @(posedge i_mclk);
      i_per_req <= 8'h03;
      pulse(0);
      take(0, 4'h8, 24'h5A0040);
      chk("fetch_seg", 8'h5A, o_fetch_seg);
      pulse(3);
      #1;
      chk("fetch_seg", 8'h5A, o_fetch_seg);
      leave("tie_break");
      take(0, 4'h9, 24'h5A0042);
      leave("shared_base");
      @(posedge i_mclk);
      i_seg_save_en <= 1'b1;
      slow <= 1'b1;
      i_ext_pin[1] <= 1'b1;
      pulse(0);
      take(0, 4'h1, 24'h5A0022);
      chk("code_seg", 8'h5A, o_code_seg);
      leave("seg_save");
      pulse(4);
      i_per_req <= 8'h0C;
      pulse(0);
      quiet(30);
      i_cpl_wdata <= 3'h4;
      pulse(4);
      take(0, 4'hA, 24'h5A0060);
      leave("priority");
      opq.delete();
      pulse(2);
      wait_ev(2);
      chk("trap_pc", {fx(24'h330002), fx(24'h330003)}, o_pc_value);
      exp_op(OP_PUSH, 24'h0, i_pc[7:0]);
      exp_op(OP_PUSH, 24'h0, i_pc[15:8]);
      exp_op(OP_FETCH, 24'h330002, 8'h0);
      // trap needs no iret; the bench drives no return
      $display("test trap done");
      i_tl_nonmask <= 1'b0;
      i_tl_pin <= 1'b1;
      quiet(30);
      i_tl_mask_en <= 1'b1;
      take(1, 4'h0, 24'h5A0004);
      chk("tl_active", 1'b1, o_tl_active);
      i_per_req <= 8'h09;
      pulse(0);
      quiet(30);
      leave("top_level");
      take(0, 4'h8, 24'h5A0040);
      leave("after_top");
      close_out();
   end
endmodule // interrupt_vectoring_priority_tb
